// *** design/mbe_bus_clock.sv ***
// Purpose: Makes or follows the bus clock and flags its edges.
// Assumes: Clock mode and divider pins are static straps.
// Notes: In output mode the high phase is the shorter for odd periods.
`timescale 1ns/1ps
module mbe_bus_clock
  import mbe_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus clock side.
  mbe_clk_if.gen ck
);

  // All state: straps, divider, pin levels, a gap counter and an edge-seen flag.
  typedef struct packed {
    logic mode;
    logic [2:0] cfg;
    logic [DIV_W-1:0] cnt;
    logic mclk;
    logic inv;
    logic oe;
    logic [DIV_W:0] gap;
    logic seen;
  } mbe_gen_t;

  mbe_gen_t s_ff; // Registered state.
  mbe_gen_t nxt_s; // Next state.
  logic [DIV_W-1:0] period; // Core cycles per bus clock period.

  // ---------------------------------------------------------------------
  // Divider and pin levels
  // ---------------------------------------------------------------------
  // Core clock divided by the setting plus two, or the input pin.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.mode = ck.mode_pin;
    nxt_s.cfg = ck.div_cfg;
    period = {1'b0, s_ff.cfg} + DIV_BASE; // see RULE21
    if (!s_ff.mode || s_ff.cnt >= period - 4'h1) begin
      nxt_s.cnt = '0;
    end else begin
      nxt_s.cnt = s_ff.cnt + 4'h1;
    end
    if (s_ff.mode) begin
      nxt_s.mclk = nxt_s.cnt < (period >> 1); // see RULE21
    end else begin
      nxt_s.mclk = ck.mclk_in; // see RULE6
    end
    nxt_s.oe = s_ff.mode; // see RULE7
    nxt_s.inv = s_ff.mode & ~ck.inv_off & ~nxt_s.mclk; // see RULE6
    nxt_s.gap = (nxt_s.mclk & ~s_ff.mclk) ? '0 : s_ff.gap + 5'h1;
    if (nxt_s.mclk & ~s_ff.mclk & s_ff.mode) begin
      nxt_s.seen = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Pins and strobes.
  assign ck.mode = s_ff.mode;
  assign ck.mclk = s_ff.mclk;
  assign ck.mclk_inv = s_ff.inv;
  assign ck.mclk_oe = s_ff.oe;
  assign ck.rise = nxt_s.mclk & ~s_ff.mclk;
  assign ck.fall = ~nxt_s.mclk & s_ff.mclk;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_inv_low;
    @(posedge i_clk) disable iff (i_rst)
    !$past(s_ff.mode) |-> !s_ff.inv && !s_ff.oe;
  endproperty
  a_inv_low: assert property (p_inv_low) // see RULE6
    else $error("inverted clock or pin drive in input mode");

  property p_out_mode;
    @(posedge i_clk) disable iff (i_rst)
    $past(s_ff.mode) && !$past(ck.inv_off) |->
      s_ff.oe && s_ff.inv == !s_ff.mclk;
  endproperty
  a_out_mode: assert property (p_out_mode) // see RULE7
    else $error("output clocks not driven in output mode");

  property p_period;
    @(posedge i_clk) disable iff (i_rst)
    ck.rise && s_ff.mode && s_ff.seen |->
      s_ff.gap + 5'h1 == {1'b0, period};
  endproperty
  a_period: assert property (p_period) // see RULE21
    else $error("bus clock period differs from setting plus two");

endmodule

// *** design/mbe_clk_if.sv ***
// Purpose: Carries bus clock pins and phase strobes between modules.
// Assumes: All signals live in the core clock domain.
// Notes: rise and fall mark the core edge at which the bus clock moves.
`timescale 1ns/1ps
interface mbe_clk_if;
  logic mode_pin; // Raw clock mode select pin.
  logic [2:0] div_cfg; // Raw bus clock divider setting.
  logic mclk_in; // Bus clock pin level when it is an input.
  logic inv_off; // Software switch that parks the inverted clock.
  logic mode; // Registered clock mode select.
  logic mclk; // Registered bus clock level.
  logic mclk_inv; // Registered inverted bus clock.
  logic mclk_oe; // High while the bus clock pin is driven.
  logic rise; // Bus clock goes high at the coming core edge.
  logic fall; // Bus clock goes low at the coming core edge.
  modport gen (input mode_pin, div_cfg, mclk_in, inv_off,
    output mode, mclk, mclk_inv, mclk_oe, rise, fall);
  modport bus (output mode_pin, div_cfg, mclk_in, inv_off,
    input mode, mclk, mclk_inv, mclk_oe, rise, fall);
endinterface

// *** design/mbe_memory_bus.sv ***
// Purpose: Memory bus front end of a core: one access at a time.
// Assumes: Pins sync to I_CLOCK; straps stay static after reset.
// Notes: Bus clock phases come from mbe_bus_clock as core strobes.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module mbe_memory_bus
  import mbe_pkg::*;
#(
  parameter int CCFG_W = 4
) (
  // Clock and reset.
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // Core request side.
  input wire logic I_REQ_VALID,
  input wire logic I_REQ_WRITE,
  input wire logic I_REQ_FETCH,
  input wire logic [1:0] I_REQ_SIZE,
  input wire logic [31:0] I_REQ_ADDR,
  input wire logic [31:0] I_REQ_WDATA,
  output logic O_REQ_READY,
  output logic O_RSP_VALID,
  output logic [31:0] O_RSP_RDATA,
  // Register port.
  input wire logic [3:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [31:0] O_REG_RDATA,
  // Memory bus.
  output logic [31:0] O_ADDR,
  output logic [1:0] O_MAS,
  output logic O_WRITE_NOT_READ,
  output logic O_MEMORY_REQUEST_N,
  output logic O_ACCESS_FOLLOWS_ON,
  output logic [31:0] O_DATA_OUT,
  output logic O_DATA_OE,
  input wire logic [31:0] I_DATA_IN,
  output logic [3:0] O_PARITY,
  input wire logic I_BUS_STALL_N,
  // Bus clock pins and straps.
  input wire logic I_MCLK,
  output logic O_MCLK,
  output logic O_MCLK_OE,
  output logic O_MEMORY_BUS_CLOCK_INV,
  input wire logic I_BUS_CLOCK_MODE_SELECT,
  input wire logic [2:0] I_BUS_CLOCK_DIVIDER_CFG,
  // Core clock selection.
  input wire logic [CCFG_W-1:0] I_CORE_CLOCK_CFG,
  input wire logic I_CORE_PLL_BYPASS,
  input wire logic I_BYPASS_CORE_CLOCK,
  input wire logic I_PLL_RATIO_SET_SELECT,
  input wire logic I_RESERVED_TIE_LOW,
  output logic O_CORE_CLOCK_FROM_BYPASS,
  output logic O_PLL_SLOW_RATIOS,
  output logic [CCFG_W-1:0] O_CORE_CLOCK_CFG
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  // All state of the bus front end in one record.
  typedef struct packed {
    mbe_acc_t st;
    logic big;
    logic inv_off;
    logic wr;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic lbig;
    logic mreq_n;
    logic fol;
    logic wnr;
    logic [1:0] mas;
    logic [31:0] bus_addr;
    logic [31:0] dout;
    logic doe;
    logic [3:0] par;
    logic ready;
    logic rsp;
    logic [31:0] rdata;
    logic [31:0] stalls;
    logic [31:0] reg_rdata;
    logic bypass;
    logic slow;
    logic [CCFG_W-1:0] ccfg;
  } mbe_main_t;

  // Reset image: request idle high, ready, slow ratio set.
  localparam mbe_main_t S_RESET = '{
    st: ACC_IDLE,
    mreq_n: REQ_IDLE_N,
    ready: READY_RESET,
    slow: SLOW_RESET,
    default: '0
  };

  mbe_main_t s_ff; // Registered state.
  mbe_main_t nxt_s; // Next state.
  logic [1:0] eff_size; // Size after forcing fetches to words.
  logic stall_clr; // Software write to the stall counter.

  // Bus clock generator link.
  mbe_clk_if ck ();

  // ---------------------------------------------------------------------
  // Bus clock generator
  // ---------------------------------------------------------------------
  assign ck.mode_pin = I_BUS_CLOCK_MODE_SELECT;
  assign ck.div_cfg = I_BUS_CLOCK_DIVIDER_CFG;
  assign ck.mclk_in = I_MCLK;
  assign ck.inv_off = s_ff.inv_off;

  mbe_bus_clock u_clk (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .ck(ck.gen)
  );

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  // Register port, access sequencer and strap capture.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.rsp = 1'b0;
    nxt_s.reg_rdata = '0;
    // Fetches and words never move lanes.
    eff_size = I_REQ_FETCH ? SIZE_WORD : I_REQ_SIZE; // see RULE18
    stall_clr = I_REG_WR && I_REG_ADDR == REG_STALLS;
    // Core clock source and ratio set follow their pins.
    nxt_s.bypass = I_CORE_PLL_BYPASS; // see RULE9
    nxt_s.slow = I_PLL_RATIO_SET_SELECT; // see RULE10
    nxt_s.ccfg = I_CORE_CLOCK_CFG;
    // Control register write.
    if (I_REG_WR && I_REG_ADDR == REG_CTRL) begin
      nxt_s.big = I_REG_WDATA[CTRL_BIG]; // see RULE14
      nxt_s.inv_off = I_REG_WDATA[CTRL_INV_OFF];
    end
    // Stall counter clears on write; a stall in that cycle still counts.
    if (stall_clr) begin
      nxt_s.stalls = '0;
    end
    // Read data appear one cycle after the strobe, zero otherwise.
    if (I_REG_RD) begin
      unique case (I_REG_ADDR)
        REG_CTRL: begin
          nxt_s.reg_rdata[CTRL_BIG] = s_ff.big;
          nxt_s.reg_rdata[CTRL_INV_OFF] = s_ff.inv_off;
        end
        REG_STATUS: begin
          nxt_s.reg_rdata[ST_MODE] = ck.mode;
          nxt_s.reg_rdata[ST_BYPASS] = s_ff.bypass;
          nxt_s.reg_rdata[ST_SLOW] = s_ff.slow;
          nxt_s.reg_rdata[ST_BUSY] = s_ff.st != ACC_IDLE;
          nxt_s.reg_rdata[ST_RSVD] = I_RESERVED_TIE_LOW;
          nxt_s.reg_rdata[ST_TCLK] = I_BYPASS_CORE_CLOCK;
        end
        REG_STALLS: begin
          nxt_s.reg_rdata = s_ff.stalls;
        end
        default: begin
          nxt_s.reg_rdata = '0;
        end
      endcase
    end
    // Access sequencer.
    unique case (s_ff.st)
      // Take a request and lay its data on the proper lanes now.
      ACC_IDLE: begin
        if (I_REQ_VALID) begin
          nxt_s.wr = I_REQ_WRITE;
          nxt_s.size = eff_size;
          nxt_s.addr = I_REQ_ADDR;
          nxt_s.lbig = s_ff.big;
          nxt_s.wdata = mbe_place(I_REQ_WDATA, I_REQ_ADDR[1:0],
            eff_size, s_ff.big); // see RULE15, RULE22
          nxt_s.ready = 1'b0;
          nxt_s.st = ACC_ANNOUNCE;
        end
      end
      // While the bus clock falls, announce the access for next cycle.
      ACC_ANNOUNCE: begin
        if (ck.fall) begin
          nxt_s.mreq_n = 1'b0; // see RULE20
          nxt_s.bus_addr = s_ff.addr;
          nxt_s.wnr = s_ff.wr; // see RULE19
          nxt_s.mas = s_ff.size;
          nxt_s.st = ACC_START;
        end
      end
      // The next rise opens the access cycle.
      ACC_START: begin
        if (ck.rise) begin
          nxt_s.st = ACC_ACCESS;
        end
      end
      // Low phase: data and parity; rise: stall or finish.
      ACC_ACCESS: begin
        if (ck.fall) begin
          nxt_s.mreq_n = REQ_IDLE_N; // see RULE20
          nxt_s.dout = s_ff.wdata;
          nxt_s.doe = s_ff.wr;
          nxt_s.par = mbe_parity(s_ff.wdata); // see RULE3, RULE4
        end
        if (ck.rise) begin
          if (!I_BUS_STALL_N) begin
            // Stall latched on the rise: one more bus cycle.
            nxt_s.stalls = (stall_clr ? '0 : s_ff.stalls) + 32'h1;
          end else begin
            nxt_s.rsp = 1'b1; // see RULE1
            nxt_s.rdata = s_ff.wr ? '0 : mbe_extract(I_DATA_IN,
              s_ff.addr[1:0], s_ff.size, s_ff.lbig); // see RULE16 RULE17
            nxt_s.doe = 1'b0;
            nxt_s.ready = READY_RESET;
            nxt_s.st = ACC_IDLE;
          end
        end
      end
    endcase
    // Follow-on indicator trails the request by half a bus cycle.
    if (ck.rise) begin
      nxt_s.fol = ~s_ff.mreq_n; // see RULE5
    end
  end

  // State register.
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      s_ff <= S_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign O_REQ_READY = s_ff.ready;
  assign O_RSP_VALID = s_ff.rsp;
  assign O_RSP_RDATA = s_ff.rdata;
  assign O_REG_RDATA = s_ff.reg_rdata;
  assign O_ADDR = s_ff.bus_addr;
  assign O_MAS = s_ff.mas;
  assign O_WRITE_NOT_READ = s_ff.wnr;
  assign O_MEMORY_REQUEST_N = s_ff.mreq_n;
  assign O_ACCESS_FOLLOWS_ON = s_ff.fol;
  assign O_DATA_OUT = s_ff.dout;
  assign O_DATA_OE = s_ff.doe;
  assign O_PARITY = s_ff.par;
  assign O_MCLK = ck.mclk;
  assign O_MCLK_OE = ck.mclk_oe;
  assign O_MEMORY_BUS_CLOCK_INV = ck.mclk_inv;
  assign O_CORE_CLOCK_FROM_BYPASS = s_ff.bypass;
  assign O_PLL_SLOW_RATIOS = s_ff.slow;
  assign O_CORE_CLOCK_CFG = s_ff.ccfg;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);

  property p_stall;
    s_ff.st == ACC_ACCESS && ck.rise && !I_BUS_STALL_N |=>
      s_ff.st == ACC_ACCESS && !O_RSP_VALID;
  endproperty
  a_stall: assert property (p_stall) // see RULE1
    else $error("stall did not extend the access");

  property p_parity;
    O_DATA_OE |-> O_PARITY == ~{^O_DATA_OUT[31:24], ^O_DATA_OUT[23:16],
      ^O_DATA_OUT[15:8], ^O_DATA_OUT[7:0]};
  endproperty
  a_parity: assert property (p_parity) // see RULE3
    else $error("parity is not odd per byte");

  property p_par_low;
    $rose(O_DATA_OE) |-> O_WRITE_NOT_READ && !O_MCLK;
  endproperty
  a_par_low: assert property (p_par_low) // see RULE4
    else $error("write data not launched in low phase");

  property p_follow;
    $changed(O_ACCESS_FOLLOWS_ON) |->
      O_MCLK && O_ACCESS_FOLLOWS_ON == !$past(O_MEMORY_REQUEST_N);
  endproperty
  a_follow: assert property (p_follow) // see RULE5
    else $error("follow-on is not the delayed inverse of request");

  property p_req;
    $fell(O_MEMORY_REQUEST_N) |-> !O_MCLK ##[1:16] $rose(O_ACCESS_FOLLOWS_ON);
  endproperty
  a_req: assert property (p_req) // see RULE20
    else $error("request not low phase or no access next cycle");

  property p_bypass;
    1'b1 |=> O_CORE_CLOCK_FROM_BYPASS == $past(I_CORE_PLL_BYPASS);
  endproperty
  a_bypass: assert property (p_bypass) // see RULE9
    else $error("core clock source does not follow bypass");

  property p_slow;
    1'b1 |=> O_PLL_SLOW_RATIOS == $past(I_PLL_RATIO_SET_SELECT);
  endproperty
  a_slow: assert property (p_slow) // see RULE10
    else $error("ratio set does not follow its select");

  sequence s_rd_end;
    s_ff.st == ACC_ACCESS && ck.rise && I_BUS_STALL_N && !s_ff.wr;
  endsequence

  property p_le_byte;
    s_rd_end and (s_ff.size == SIZE_BYTE && !s_ff.lbig &&
      s_ff.addr[1:0] == 2'h0) |=>
      O_RSP_RDATA == {24'h0, $past(I_DATA_IN[7:0])};
  endproperty
  a_le_byte: assert property (p_le_byte) // see RULE16
    else $error("little endian byte zero not from low lane");

  property p_be_byte;
    s_rd_end and (s_ff.size == SIZE_BYTE && s_ff.lbig &&
      s_ff.addr[1:0] == 2'h0) |=>
      O_RSP_RDATA == {24'h0, $past(I_DATA_IN[31:24])};
  endproperty
  a_be_byte: assert property (p_be_byte) // see RULE17
    else $error("big endian byte zero not from high lane");

  property p_word;
    s_rd_end and (s_ff.size == SIZE_WORD) |=>
      O_RSP_RDATA == $past(I_DATA_IN);
  endproperty
  a_word: assert property (p_word) // see RULE18
    else $error("word read was moved between lanes");

  property p_wnr;
    $fell(O_MEMORY_REQUEST_N) |-> O_WRITE_NOT_READ == s_ff.wr;
  endproperty
  a_wnr: assert property (p_wnr) // see RULE19
    else $error("direction does not match the access");

  property p_half;
    $rose(O_DATA_OE) && O_MAS == SIZE_HALF |->
      ((s_ff.addr[1] ^ s_ff.lbig) ? O_DATA_OUT[15:0] == 16'h0
                                  : O_DATA_OUT[31:16] == 16'h0);
  endproperty
  a_half: assert property (p_half) // see RULE22
    else $error("halfword on wrong lanes");

  c_write: cover property (O_RSP_VALID && s_ff.wr);
  c_read: cover property (O_RSP_VALID && !s_ff.wr);
  c_stall: cover property (s_ff.st == ACC_ACCESS && ck.rise &&
    !I_BUS_STALL_N);

endmodule

// *** design/mbe_pkg.sv ***
// Purpose: Shared constants, types and lane helpers for the memory bus.
// Assumes: One core clock; bus clock edges are seen as core strobes.
// Notes: The operation summary below lists each behaviour by its tag.
// Operation
// RULE1: Sample stall at bus rise; low extends access.
// RULE2: Memory drives stall low before that rise.
// RULE3: Four odd parity bits, one per lane.
// RULE4: Write parity valid while bus clock low.
// RULE5: Follow-on output inverts request, changes when high.
// RULE6: Mode low: bus clock input, inverse held low.
// RULE7: Mode high: both bus clocks driven out; the inverse is held low while inv_off is set.
// RULE8: Mode select never changes during operation.
// RULE9: Bypass high selects test clock as core.
// RULE10: Ratio select high picks slower legacy set.
// RULE11: Test clock tied low when bypass low.
// RULE12: Test reset pulsed low besides system reset.
// RULE13: Reserved input tied permanently low.
// RULE14: Control bit selects big or little endian.
// RULE15: Four consecutive byte addresses form one word.
// RULE16: Little endian: byte zero on lanes 7:0.
// RULE17: Big endian: byte zero on lanes 31:24.
// RULE18: Endian affects only byte and halfword accesses.
// RULE19: Write-not-read high on writes, address timing.
// RULE20: Request low means access next bus cycle.
// RULE21: Output bus clock is core divided by cfg+2.
// RULE22: Halfword lanes follow address bit one, endianness.
package mbe_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_STALLS = 4'h8;
  localparam int CTRL_BIG = 0;
  localparam int CTRL_INV_OFF = 1;
  localparam int ST_MODE = 0;
  localparam int ST_BYPASS = 1;
  localparam int ST_SLOW = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_RSVD = 4;
  localparam int ST_TCLK = 5;

  // ---------------------------------------------------------------------
  // Reset values, sizes and clock constants
  // ---------------------------------------------------------------------
  localparam logic REQ_IDLE_N = 1'b1;
  localparam logic SLOW_RESET = 1'b1;
  localparam logic READY_RESET = 1'b1;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_BASE = 4'h2;

  // Access sequencer states.
  typedef enum logic [1:0] {
    ACC_IDLE, ACC_ANNOUNCE, ACC_START, ACC_ACCESS
  } mbe_acc_t;

  // ---------------------------------------------------------------------
  // Lane helpers
  // ---------------------------------------------------------------------
  // Lowest lane used by an item; a word always starts at lane zero.
  function automatic logic [1:0] mbe_lane(input logic [1:0] a,
      input logic [1:0] size, input logic big);
    logic [1:0] lane;
    lane = 2'h0;
    if (size == SIZE_BYTE) begin
      lane = big ? ~a : a;
    end else if (size == SIZE_HALF) begin
      lane = {a[1] ^ big, 1'b0};
    end
    return lane;
  endfunction

  // Moves a right-aligned item onto its lanes; other lanes read zero.
  function automatic logic [31:0] mbe_place(input logic [31:0] d,
      input logic [1:0] a, input logic [1:0] size, input logic big);
    logic [31:0] v;
    v = d;
    if (size == SIZE_BYTE) begin
      v = {24'h0, d[7:0]};
    end else if (size == SIZE_HALF) begin
      v = {16'h0, d[15:0]};
    end
    return v << {mbe_lane(a, size, big), 3'h0};
  endfunction

  // Takes an item off its lanes and right-aligns it, zero extended.
  function automatic logic [31:0] mbe_extract(input logic [31:0] d,
      input logic [1:0] a, input logic [1:0] size, input logic big);
    logic [31:0] v;
    v = d >> {mbe_lane(a, size, big), 3'h0};
    if (size == SIZE_BYTE) begin
      v = {24'h0, v[7:0]};
    end else if (size == SIZE_HALF) begin
      v = {16'h0, v[15:0]};
    end
    return v;
  endfunction

  // Odd parity per byte: each lane plus its bit holds an odd count.
  function automatic logic [3:0] mbe_parity(input logic [31:0] d);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 4; i++) begin
      p[i] = ~^d[8*i +: 8];
    end
    return p;
  endfunction

endpackage

// *** sim/mbe_mem_model.sv ***
// Purpose: Memory system model facing the memory bus pins.
// Assumes: The bus clock level is seen once per core cycle.
// Notes: Each access is stalled for a count that the bench sets.
`timescale 1ns/1ps
module mbe_mem_model (
  // Bus pins seen from memory.
  input wire logic i_clk,
  input wire logic i_big,
  input wire logic [31:0] i_addr,
  input wire logic [1:0] i_mas,
  input wire logic i_wnr,
  input wire logic i_fol,
  input wire logic i_mclk,
  input wire logic [31:0] i_wd,
  input wire logic i_oe,
  // Stall setting from the bench.
  input wire logic [3:0] i_nst,
  input wire logic i_go,
  // Answers.
  output logic o_stall_n,
  output logic [31:0] o_rd
);
  logic [31:0] mem [16]; // Word store.
  logic [31:0] last = 32'h0; // Last level left on the data lines.
  logic [3:0] left = 4'h0; // Stalled rises still owed.
  logic mclk_q = 1'b0; // Bus clock one core cycle ago.
  logic st_q = 1'b1; // Stall level one core cycle ago.
  logic act = 1'b0; // Access still open after follow-on drops.
  logic [3:0] ln; // Lanes written by this access.
  logic [1:0] a; // Byte number inside the word.
  assign a = i_addr[1:0];
  // A byte or halfword lands on the lanes its address and order pick.
  assign ln = (i_mas == 2'h1) ? 4'h3 << {a[1] ^ i_big, 1'b0} :
    (i_mas == 2'h0) ? 4'h1 << (i_big ? ~a : a) : 4'hf;
  // Stall goes low ahead of the rise that would end the access.
  assign o_stall_n = !((i_fol || act) && left != 4'h0);
  // Released lines show the inverse of the last value, never a hold.
  assign o_rd = ((i_fol || act) && !i_wnr) ? mem[i_addr[5:2]] :
    ~last;
  // Counts stalled rises and stores write lanes.
  always @(posedge i_clk) begin
    mclk_q <= i_mclk;
    st_q <= o_stall_n;
    // The access stays open until a rise that was not stalled.
    if (i_fol) begin
      act <= 1'b1;
    end else if (i_mclk && !mclk_q && st_q) begin
      act <= 1'b0;
    end
    last <= o_rd;
    if (i_go) begin
      left <= i_nst;
    end else if (i_mclk && !mclk_q && !st_q && left != 4'h0) begin
      left <= left - 4'h1;
    end
    for (int i = 0; i < 4; i++) begin
      if (i_oe && ln[i]) begin
        mem[i_addr[5:2]][8*i +: 8] <= i_wd[8*i +: 8];
      end
    end
  end
endmodule

// *** sim/mbe_memory_bus_tb.sv ***
// Purpose: Self-checking bench for the memory bus front end.
// Assumes: Output bus clock mode until a last reset into input mode; straps settle before reset ends.
// Notes: Drivers queue expected results and a monitor checks them.
`timescale 1ns/1ps
module mbe_memory_bus_tb
  import mbe_pkg::*;
;
  logic clk, big, byp, slo, bus_clock_mode_select = 1'b1, imc = 1'b0;
  logic rst = 1'b1, rv = 1'b0, rw = 1'b0, rf = 1'b0, rd_q = 1'b0;
  logic gw = 1'b0, gr = 1'b0, stg = 1'b0;
  logic [1:0] rs = 2'h0;
  logic [2:0] div;
  logic [3:0] ga = 4'h0, cc, stc = 4'h0;
  logic [31:0] ra = 32'h0, rwd = 32'h0, gd = 32'h0, w, a;
  wire logic stn, rsv, wnr, fol, doe, mck, mce, inv, byo, slw, rdy, mrq;
  wire logic [31:0] rsd, grd, oad, dout, din;
  wire logic [1:0] mas;
  wire logic [3:0] par, cco;
  logic [31:0] rsp_q[$]; // Expected access results.
  logic [31:0] reg_q[$]; // Expected register reads.
  int fail_count = 0;
  int checks = 0;
  int ln;
  mbe_memory_bus dut_u (.I_CLOCK(clk), .I_SYS_RST(rst), .I_REQ_VALID(rv),
    .I_REQ_WRITE(rw), .I_REQ_FETCH(rf), .I_REQ_SIZE(rs), .I_REQ_ADDR(ra),
    .I_REQ_WDATA(rwd), .O_REQ_READY(rdy), .O_RSP_VALID(rsv),
    .O_RSP_RDATA(rsd), .I_REG_ADDR(ga), .I_REG_WDATA(gd), .I_REG_WR(gw),
    .I_REG_RD(gr), .O_REG_RDATA(grd), .O_ADDR(oad), .O_MAS(mas),
    .O_WRITE_NOT_READ(wnr), .O_MEMORY_REQUEST_N(mrq),
    .O_ACCESS_FOLLOWS_ON(fol), .O_DATA_OUT(dout), .O_DATA_OE(doe),
    .I_DATA_IN(din), .O_PARITY(par), .I_BUS_STALL_N(stn), .I_MCLK(imc),
    .O_MCLK(mck), .O_MCLK_OE(mce), .O_MEMORY_BUS_CLOCK_INV(inv),
    .I_BUS_CLOCK_MODE_SELECT(bus_clock_mode_select), .I_BUS_CLOCK_DIVIDER_CFG(div),
    .I_CORE_CLOCK_CFG(cc), .I_CORE_PLL_BYPASS(byp),
    .I_BYPASS_CORE_CLOCK(1'b0), .I_RESERVED_TIE_LOW(1'b0),
    .I_PLL_RATIO_SET_SELECT(slo), .O_CORE_CLOCK_FROM_BYPASS(byo),
    .O_PLL_SLOW_RATIOS(slw), .O_CORE_CLOCK_CFG(cco));
  mbe_mem_model mem_u (.i_clk(clk), .i_big(big), .i_addr(oad), .i_mas(mas),
    .i_wnr(wnr), .i_fol(fol), .i_mclk(mck), .i_wd(dout), .i_oe(doe),
    .i_nst(stc), .i_go(stg), .o_stall_n(stn), .o_rd(din));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Compares one value and counts the outcome.
  task automatic cmp(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One register cycle; a read carries its expected value in d.
  task automatic reg_op(input logic wr, input logic [3:0] ad,
      input logic [31:0] d);
    @(posedge clk);
    ga <= ad;
    gd <= d;
    gw <= wr;
    gr <= !wr;
    if (!wr) reg_q.push_back(d);
    @(posedge clk);
    gw <= 1'b0;
    gr <= 1'b0;
  endtask
  // One memory access with ns stalled rises, waited for under a bound.
  task automatic acc(input logic wr, f, input logic [1:0] s,
      input logic [31:0] ad, d, ex, input logic [3:0] ns);
    int n = 0;
    @(posedge clk);
    stc <= ns;
    stg <= 1'b1;
    @(posedge clk);
    stg <= 1'b0;
    rv <= 1'b1;
    rw <= wr;
    rf <= f;
    rs <= s;
    ra <= ad;
    rwd <= d;
    rsp_q.push_back(ex);
    @(posedge clk);
    rv <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rsv !== 1'b1 && n < 300);
    if (n >= 300) fail_count++;
  endtask
  // Monitor: takes the oldest note whenever a result appears.
  always @(posedge clk) begin
    rd_q <= gr;
    if (rd_q === 1'b1) cmp("reg", reg_q.pop_front(), grd);
    if (rsv === 1'b1) cmp("rsp", rsp_q.pop_front(), rsd);
    if (rsv === 1'b1) cmp("idle", 2'h3, {rdy, mrq});
    for (int i = 0; i < 4; i++) begin
      if (doe === 1'b1) cmp("par", 1, ^{dout[8*i +: 8], par[i]});
    end
  end
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
  initial begin
    void'($urandom(32'h68aab33a));
    byp = 1'($urandom);
    slo = 1'($urandom);
    cc = 4'($urandom);
    div = 3'($urandom % 3);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
    cmp("mclk_oe", 1, mce);
    cmp("mclk_inv", 1, mck ^ inv);
    cmp("bypass", byp, byo);
    cmp("slow", slo, slw);
    cmp("ccfg", cc, cco);
    reg_op(0, 4'h4, {29'h0, slo, byp, 1'b1});
    reg_op(0, 4'hc, 32'h0);
    for (int b = 0; b < 2; b++) begin
      big = b[0];
      reg_op(1, 4'h0, {31'h0, big});
      for (int k = 0; k < 4; k++) begin
        w = $urandom;
        a = {26'h0, 4'($urandom), 2'(k)};
        ln = big ? 3 - k : k;
        acc(1, 0, SIZE_WORD, a & ~32'h3, w, 0, 0);
        reg_op(1, 4'h8, 32'h0);
        acc(0, 0, SIZE_BYTE, a, 0, w[8*ln +: 8], 4'(k));
        reg_op(0, 4'h8, k);
        acc(0, 0, SIZE_HALF, a, 0, w[16*((k / 2) ^ b) +: 16], 0);
        acc(1, 0, SIZE_HALF, a, w >> 16 * ((k / 2) ^ b), 0, 0);
        acc(0, 1, SIZE_BYTE, a, 0, w, 0);
        acc(1, 0, SIZE_BYTE, a, {24'h0, ~w[8*ln +: 8]}, 0, 0);
        w[8*ln +: 8] = ~w[8*ln +: 8];
        acc(0, 0, SIZE_WORD, a & ~32'h3, 0, w, 0);
      end
    end
    // Second reset into input clock mode; the pin level must pass through.
    rst <= 1'b1;
    bus_clock_mode_select <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    imc <= 1'b1;
    reg_op(0, 4'h4, {29'h0, slo, byp, 1'b0});
    repeat (2) @(posedge clk);
    cmp("in_mode", 3'h4, {mck, mce, inv});
    final_report();
  end
endmodule
